// file: verilog/sync_serial_and_multidrop_port.sv
// Clocked synchronous serial port with multiprocessor-format transmitter
//
// Overview of operation
// (RULE_01) Transmit bit changes on serial clock falling edge, holds until next falling edge.
// (RULE_02) Characters leave least significant bit first, bit 0 to bit 7.
// (RULE_03) After the last bit the line keeps the MSB level until new data.
// (RULE_04) Receive data is sampled on the rising serial clock edge.
// (RULE_05) Synchronous characters are always 8 bits, no parity, no address bit.
// (RULE_06) Internal clock gives exactly eight pulses per character.
// (RULE_07) Internal clock pin stays high whenever no transfer is running.
// (RULE_08) Transmit and receive run together on one clock, each double buffered.
// (RULE_09) External clock: transmit data follows the supplied clock edges.
// (RULE_10) Empty flag low: load shifter, set flag, start, request empty interrupt.
// (RULE_11) At bit 7: more data continues, else set done flag and hold line.
// (RULE_12) No transmit start while overrun, framing or parity error is set.
// (RULE_13) Receiver follows the serial clock, shifts bits in LSB first.
// (RULE_14) Complete character with full flag clear: copy, set full, request interrupt.
// (RULE_15) Complete character with full flag set: set overrun, keep full, request error.
// (RULE_16) No reception while any receive error or full flag is set; duplex transfers still receive with the full flag set.
// (RULE_17) Software enters duplex from transmit via disable, then both enables together.
// (RULE_18) Software enters duplex from receive after flags clear, both enables together.
// (RULE_19) Address bit is 1 on identifier frames, 0 on data frames.
// (RULE_20) Receivers skip data frames after a foreign identifier until next address frame.
// (RULE_21) Parity settings are ignored in multiprocessor format.
// (RULE_22) Stop bit with nothing queued: set done flag, idle the line high.
// (RULE_23) Transmit disable forces empty flag high; receive disable keeps receive state.
// (RULE_24) Writing transmit data clears the empty flag; loading the shifter sets it.
// (RULE_25) Clock source chosen from mode and the two clock-select bits.
// (RULE_26) Transmit empty and done interrupts are levels while flag and enable are high.
`timescale 1ns/100ps
`default_nettype none
module sync_serial_and_multidrop_port (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Mode and enables
    input  wire logic       sync_mode,
    input  wire logic       mp_format,
    input  wire logic       clock_source_sel_hi,
    input  wire logic       clock_source_sel_lo,
    input  wire logic       tx_enable_bit,
    input  wire logic       rx_enable_bit,
    input  wire logic       tx_empty_irq_en,
    input  wire logic       tx_done_irq_en,
    input  wire logic       rx_irq_en,
    // Software access
    input  wire logic       tx_write,
    input  wire logic [7:0] tx_data,
    input  wire logic       address_flag_bit,
    input  wire logic       rx_full_clear,
    input  wire logic       overrun_clear,
    input  wire logic       rx_error_ext,
    // Pins
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    input  wire logic       rx_line_pin,
    output logic            tx_line_pin,
    // Status
    output logic            tx_empty_flag,
    output logic            tx_done_flag,
    output logic            rx_full_flag,
    output logic            overrun_flag,
    output logic [7:0]      rx_holding_reg,
    // Interrupt requests
    output logic            tx_empty_irq,
    output logic            tx_done_irq,
    output logic            rx_full_irq,
    output logic            rx_error_irq
);
    import serial_port_pkg::*;

    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] pin_rise;
    logic [PIN_COUNT-1:0] pin_fall;

    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  ({rx_line_pin, serial_clock_pin_in}),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    xfer_state_t      state_reg,    state_next;
    logic [DIV_W-1:0] div_reg,      div_next;
    logic [CNT_W-1:0] bit_cnt_reg,  bit_cnt_next;
    logic [CNT_W-1:0] base_cnt_reg, base_cnt_next;
    logic [10:0]      tx_shift_reg, tx_shift_next;
    logic [7:0]       rx_shift_reg, rx_shift_next;
    logic             tx_live_reg,  tx_live_next;
    logic             rx_live_reg,  rx_live_next;
    logic             sck_reg,      sck_next;
    logic             txd_reg,      txd_next;
    logic [7:0]       tx_holding_reg;
    logic             addr_hold_reg;
    logic             tx_empty_reg, tx_empty_next;
    logic             tx_done_reg,  tx_done_next;
    logic             rx_full_reg,  rx_full_next;
    logic             overrun_reg,  overrun_next;
    logic [7:0]       rx_hold_next;
    logic             sck_oe_reg,   sck_oe_next;

    logic ext_clk;
    logic errs;
    logic tx_go;
    logic rx_solo;
    logic half_tick;
    logic fall_ev;
    logic rise_ev;
    logic tx_load;
    logic char_end;
    logic rx_capture;
    logic ovr_set;

    // Internal generator unless the high clock-select bit picks the pin
    assign ext_clk = clock_source_sel_hi;  // see RULE_25
    assign errs    = overrun_reg | rx_error_ext;
    assign tx_go   = tx_enable_bit & ~tx_empty_reg & ~errs;  // see RULE_12
    assign rx_solo = rx_enable_bit & ~tx_enable_bit & ~rx_full_reg & ~errs;  // see RULE_16

    always_comb
    begin
        state_next    = state_reg;
        div_next      = div_reg;
        bit_cnt_next  = bit_cnt_reg;
        base_cnt_next = base_cnt_reg;
        tx_shift_next = tx_shift_reg;
        rx_shift_next = rx_shift_reg;
        tx_live_next  = tx_live_reg;
        rx_live_next  = rx_live_reg;
        sck_next      = sck_reg;
        txd_next      = txd_reg;
        tx_load       = 1'b0;
        char_end      = 1'b0;
        half_tick     = 1'b0;
        if (state_reg != ST_IDLE)
        begin
            if (div_reg == DIV_LAST)
            begin
                div_next  = '0;
                half_tick = 1'b1;
            end
            else
            begin
                div_next = div_reg + 1'b1;
            end
        end
        else
        begin
            div_next = '0;
        end
        fall_ev = ext_clk ? pin_fall[PIN_SCK] : (half_tick & sck_reg);  // see RULE_09
        rise_ev = ext_clk ? pin_rise[PIN_SCK] : (half_tick & ~sck_reg);
        unique case (state_reg)
            ST_IDLE:
            begin
                bit_cnt_next  = '0;
                base_cnt_next = '0;
                if (sync_mode && (tx_go || rx_solo))
                begin
                    state_next    = ST_SYNC;
                    tx_live_next  = tx_go;
                    // Duplex receive may still run with the full flag set, so overrun can be seen
                    rx_live_next  = rx_enable_bit & ~errs;  // see RULE_08
                    // Fixed 8-bit character, no extra bits in this mode
                    tx_shift_next = {3'b111, tx_holding_reg};  // see RULE_05
                    tx_load       = tx_go;  // see RULE_10
                end
                else if (!sync_mode && mp_format && tx_go)
                begin
                    state_next    = ST_ASYNC;
                    tx_live_next  = 1'b1;
                    rx_live_next  = 1'b0;
                    // Stop, address bit, data, start; no parity slot whatever the parity setting
                    tx_shift_next = {1'b1, addr_hold_reg, tx_holding_reg, 1'b0};  // see RULE_19, RULE_21
                    txd_next      = 1'b0;
                    tx_load       = 1'b1;  // see RULE_10
                end
            end
            ST_SYNC:
            begin
                if (!ext_clk && half_tick)
                begin
                    sck_next = ~sck_reg;  // see RULE_06
                end
                if (!tx_enable_bit)
                begin
                    tx_live_next = 1'b0;
                end
                if (fall_ev && tx_live_reg)
                begin
                    txd_next      = tx_shift_reg[0];  // see RULE_01, RULE_02
                    tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                end
                if (rise_ev)
                begin
                    rx_shift_next = {pin_level[PIN_RXD], rx_shift_reg[7:1]};  // see RULE_04, RULE_13
                    if (bit_cnt_reg == SYNC_LAST_BIT)
                    begin
                        char_end   = 1'b1;  // see RULE_11
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        bit_cnt_next = bit_cnt_reg + 1'b1;
                    end
                end
                if (!sync_mode)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_ASYNC:
            begin
                if (ext_clk ? pin_rise[PIN_SCK] : half_tick)
                begin
                    if (base_cnt_reg == (ext_clk ? ASYNC_EXT_LAST : ASYNC_INT_LAST))
                    begin
                        base_cnt_next = '0;
                        txd_next      = tx_shift_reg[1];
                        tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                        if (bit_cnt_reg == FRAME_LAST_BIT)
                        begin
                            // Line rests at mark after the stop bit
                            char_end   = 1'b1;  // see RULE_22
                            state_next = ST_IDLE;
                        end
                        else
                        begin
                            bit_cnt_next = bit_cnt_reg + 1'b1;
                        end
                    end
                    else
                    begin
                        base_cnt_next = base_cnt_reg + 1'b1;
                    end
                end
                if (!tx_enable_bit || sync_mode)
                begin
                    txd_next   = LINE_IDLE;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // Pin rests high between characters
        if (state_next != ST_SYNC)
        begin
            sck_next = SCK_IDLE;  // see RULE_07
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= ST_IDLE;
            div_reg      <= '0;
            bit_cnt_reg  <= '0;
            base_cnt_reg <= '0;
            tx_shift_reg <= '1;
            rx_shift_reg <= '0;
            tx_live_reg  <= 1'b0;
            rx_live_reg  <= 1'b0;
            sck_reg      <= SCK_IDLE;
            txd_reg      <= LINE_IDLE;
        end
        else
        begin
            state_reg    <= state_next;
            div_reg      <= div_next;
            bit_cnt_reg  <= bit_cnt_next;
            base_cnt_reg <= base_cnt_next;
            tx_shift_reg <= tx_shift_next;
            rx_shift_reg <= rx_shift_next;
            tx_live_reg  <= tx_live_next;
            rx_live_reg  <= rx_live_next;
            sck_reg      <= sck_next;
            txd_reg      <= txd_next;  // see RULE_03
        end
    end

    assign rx_capture = char_end & rx_live_reg & (state_reg == ST_SYNC) & ~rx_full_reg;  // see RULE_14
    assign ovr_set    = char_end & rx_live_reg & (state_reg == ST_SYNC) & rx_full_reg;  // see RULE_15

    always_comb
    begin
        // A write wins over a same-cycle load: the old word moves, the new one stays queued
        if (!tx_enable_bit)
        begin
            tx_empty_next = 1'b1;  // see RULE_23
        end
        else if (tx_write)
        begin
            tx_empty_next = 1'b0;  // see RULE_24
        end
        else if (tx_load)
        begin
            tx_empty_next = 1'b1;  // see RULE_24
        end
        else
        begin
            tx_empty_next = tx_empty_reg;
        end
        if (char_end && tx_live_reg && tx_empty_reg)
        begin
            tx_done_next = 1'b1;  // see RULE_11, RULE_22
        end
        else if (tx_write || tx_load)
        begin
            tx_done_next = 1'b0;
        end
        else
        begin
            tx_done_next = tx_done_reg;
        end
        // Receive disable touches none of these
        rx_full_next = rx_capture | (rx_full_reg & ~rx_full_clear);  // see RULE_23
        overrun_next = ovr_set | (overrun_reg & ~overrun_clear);
        rx_hold_next = rx_capture ? rx_shift_next : rx_holding_reg;
        sck_oe_next  = sync_mode & ~clock_source_sel_hi & ~clock_source_sel_lo;  // see RULE_25
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_holding_reg <= '0;
            addr_hold_reg  <= 1'b0;
            tx_empty_reg   <= TX_EMPTY_RST;
            tx_done_reg    <= TX_DONE_RST;
            rx_full_reg    <= 1'b0;
            overrun_reg    <= 1'b0;
            rx_holding_reg <= '0;
            sck_oe_reg     <= 1'b0;
            tx_empty_irq   <= 1'b0;
            tx_done_irq    <= 1'b0;
            rx_full_irq    <= 1'b0;
            rx_error_irq   <= 1'b0;
        end
        else
        begin
            if (tx_write)
            begin
                tx_holding_reg <= tx_data;
                addr_hold_reg  <= address_flag_bit;  // see RULE_19, RULE_20
            end
            tx_empty_reg   <= tx_empty_next;
            tx_done_reg    <= tx_done_next;
            rx_full_reg    <= rx_full_next;
            overrun_reg    <= overrun_next;
            rx_holding_reg <= rx_hold_next;
            sck_oe_reg     <= sck_oe_next;
            tx_empty_irq   <= tx_empty_next & tx_empty_irq_en;  // see RULE_26
            tx_done_irq    <= tx_done_next & tx_done_irq_en;  // see RULE_26
            rx_full_irq    <= rx_full_next & rx_irq_en;  // see RULE_14
            rx_error_irq   <= overrun_next & rx_irq_en;  // see RULE_15
        end
    end

    assign serial_clock_pin_out = sck_reg;
    assign serial_clock_pin_oe  = sck_oe_reg;
    assign tx_line_pin          = txd_reg;
    assign tx_empty_flag        = tx_empty_reg;
    assign tx_done_flag         = tx_done_reg;
    assign rx_full_flag         = rx_full_reg;
    assign overrun_flag         = overrun_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_sck_idle_high: assert property (state_reg == ST_IDLE |-> serial_clock_pin_out)  // see RULE_07
        else $error("serial clock not high while idle");
    a_tx_lsb_first: assert property ((state_reg == ST_SYNC && fall_ev && tx_live_reg)
        |=> tx_line_pin == $past(tx_shift_reg[0]))  // see RULE_02
        else $error("transmit bit not taken from shifter bit 0");
    a_txd_fall_only: assert property ((state_reg == ST_SYNC && !fall_ev) |=> $stable(tx_line_pin))  // see RULE_01
        else $error("transmit line moved away from a falling edge");
    a_msb_holds: assert property ((state_reg == ST_IDLE && sync_mode) |=> $stable(tx_line_pin))  // see RULE_03
        else $error("transmit line changed after the last bit");
    a_eight_pulses: assert property ((state_reg == ST_SYNC && rise_ev && bit_cnt_reg == SYNC_LAST_BIT)
        |=> state_reg == ST_IDLE && serial_clock_pin_out)  // see RULE_06
        else $error("character did not end after eight clock pulses");
    a_load_sets_empty: assert property ((tx_load && !tx_write) |=> tx_empty_flag && !tx_done_flag)  // see RULE_10
        else $error("load did not set the empty flag");
    a_write_clears: assert property ((tx_write && tx_enable_bit) |=> !tx_empty_flag)  // see RULE_24
        else $error("write did not clear the empty flag");
    a_disable_empty: assert property (!tx_enable_bit |=> tx_empty_flag)  // see RULE_23
        else $error("transmit disable did not force empty");
    a_no_start_err: assert property (errs |-> !tx_load)  // see RULE_12
        else $error("transmit started with an error flag set");
    a_rx_capture: assert property (rx_capture |=> rx_full_flag && rx_holding_reg == $past(rx_shift_next))  // see RULE_14
        else $error("received character not captured");
    a_overrun_set: assert property (ovr_set |=> overrun_flag && rx_full_flag ##1 rx_error_irq || !rx_irq_en)  // see RULE_15
        else $error("overrun not flagged");
    a_done_level: assert property ((tx_done_flag && tx_done_irq_en) [*2] |-> tx_done_irq)  // see RULE_26
        else $error("done interrupt not held as a level");
    a_start_bit: assert property ((tx_load && state_next == ST_ASYNC) |=> !tx_line_pin [*2])  // see RULE_22
        else $error("multiprocessor frame did not open with a start bit");

    c_sync_char: cover property (state_reg == ST_SYNC && char_end && tx_live_reg && rx_live_reg);
    c_overrun: cover property (ovr_set);
    c_async_end: cover property (state_reg == ST_ASYNC && char_end);
    c_back_to_back: cover property (char_end ##[1:4] tx_load);
endmodule : sync_serial_and_multidrop_port
`default_nettype wire

// file: verilog/serial_port_pkg.sv
// Constants and types shared by the synchronous serial port design
package serial_port_pkg;
    // System clock and internal serial clock timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SCK_HALF_NS     = 400;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : SCK_HALF_NS / CLK_PERIOD_NS;
    localparam int DIV_W           = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYCLES - 1);
    // Character layout
    localparam int CHAR_BITS       = 8;
    localparam int FRAME_BITS      = 11;
    localparam int CNT_W           = 4;
    localparam logic [CNT_W-1:0] SYNC_LAST_BIT  = CNT_W'(CHAR_BITS - 1);
    localparam logic [CNT_W-1:0] FRAME_LAST_BIT = CNT_W'(FRAME_BITS - 1);
    // Base ticks per asynchronous bit: external 16x clock, or two internal half periods
    localparam logic [CNT_W-1:0] ASYNC_EXT_LAST = 4'hf;
    localparam logic [CNT_W-1:0] ASYNC_INT_LAST = 4'h1;
    // Pin synchroniser bit positions
    localparam int PIN_SCK         = 0;
    localparam int PIN_RXD         = 1;
    localparam int PIN_COUNT       = 2;
    // Values after reset
    localparam logic TX_EMPTY_RST  = 1'b1;
    localparam logic TX_DONE_RST   = 1'b1;
    localparam logic LINE_IDLE     = 1'b1;
    localparam logic SCK_IDLE      = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SYNC  = 3'b010,
        ST_ASYNC = 3'b100
    } xfer_state_t;
endpackage : serial_port_pkg

// file: verilog/pin_sync.sv
// Two-stage synchroniser with edge detection for input pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Raw pins
    input  wire logic [WIDTH-1:0] pin_in,
    // Synchronised level and one-cycle edge pulses
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] hist_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                    hist_reg[i] <= 1'b1;
                end
                else
                begin
                    meta_reg[i] <= pin_in[i];
                    sync_reg[i] <= meta_reg[i];
                    hist_reg[i] <= sync_reg[i];
                end
            end
            assign level[i] = sync_reg[i];
            assign rise[i]  = sync_reg[i] & ~hist_reg[i];
            assign fall[i]  = ~sync_reg[i] & hist_reg[i];
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// file: verification/serial_peer_model.sv
// Behavioural peer device on the synchronous serial link
`timescale 1ns/100ps
`default_nettype none
module serial_peer_model (
    // Link pins
    input  wire logic       sck,
    input  wire logic       tx_line,
    output logic            rx_line,
    output logic            sck_drive,
    // Bench control, both act on any toggle
    input  wire logic       arm,
    input  wire logic       ext_go,
    input  wire logic [7:0] send_byte,
    // Last eight bits captured
    output logic [7:0]      got_byte
);
    int idx = 0;
    initial
    begin
        rx_line   = 1'b0;
        sck_drive = 1'b1;
        got_byte  = 8'h00;
    end
    always @(arm) idx = 0;
    // New bit on each falling edge, LSB first
    always @(negedge sck)
    begin
        rx_line = send_byte[idx % 8];
        idx     = idx + 1;
    end
    // Take the bit on the rising edge, then spoil the line once its hold is over
    always @(posedge sck)
    begin
        got_byte = {tx_line, got_byte[7:1]};
        #200 rx_line = ~rx_line;
    end
    // Eight pulses of 800 ns per toggle, clock stands high between characters
    always @(ext_go)
    begin
        // Start off the system clock edge so the pin flops never race the clock
        #30;
        repeat (8)
        begin
            #400 sck_drive = 1'b0;
            #400 sck_drive = 1'b1;
        end
    end
endmodule : serial_peer_model
`default_nettype wire

// file: verification/sync_serial_and_multidrop_port_tb.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none
module sync_serial_and_multidrop_port_tb;
    logic       clk_sys = 1'b0, rst = 1'b1, sync_mode = 1'b1, sel_hi = 1'b0;
    logic       tx_en = 1'b0, rx_en = 1'b0, ien = 1'b0, tx_write = 1'b0, rf_clr = 1'b0, ov_clr = 1'b0;
    logic       arm = 1'b0, ext_go = 1'b0, mp = 1'b0, mp_addr = 1'b0, ext_err = 1'b0;
    logic [7:0] tx_data = 8'h00, send_byte = 8'h00;
    logic       sck_out, sck_oe, tx_line, tx_empty, tx_done, rx_full, overrun;
    logic       irq_te, irq_td, irq_rf, irq_re, rx_line, sck_drive;
    logic [7:0] rx_hold, got;
    wire        sck = sck_oe ? sck_out : sck_drive;
    int         fails = 0, check_count = 0, cyc = 0, falls = 0, seed = 21612;

    sync_serial_and_multidrop_port DUT (.clk_sys(clk_sys), .rst(rst), .sync_mode(sync_mode), .mp_format(mp),
        .clock_source_sel_hi(sel_hi), .clock_source_sel_lo(1'b0), .tx_enable_bit(tx_en), .rx_enable_bit(rx_en),
        .tx_empty_irq_en(ien), .tx_done_irq_en(ien), .rx_irq_en(ien), .tx_write(tx_write), .tx_data(tx_data),
        .address_flag_bit(mp_addr), .rx_full_clear(rf_clr), .overrun_clear(ov_clr), .rx_error_ext(ext_err),
        .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
        .rx_line_pin(rx_line), .tx_line_pin(tx_line), .tx_empty_flag(tx_empty), .tx_done_flag(tx_done),
        .rx_full_flag(rx_full), .overrun_flag(overrun), .rx_holding_reg(rx_hold), .tx_empty_irq(irq_te),
        .tx_done_irq(irq_td), .rx_full_irq(irq_rf), .rx_error_irq(irq_re));
    serial_peer_model peer (.sck(sck), .tx_line(tx_line), .rx_line(rx_line), .sck_drive(sck_drive),
        .arm(arm), .ext_go(ext_go), .send_byte(send_byte), .got_byte(got));

    always #50 clk_sys = ~clk_sys;
    always @(negedge sck) if (!rst) falls++;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            stop_test();
        end
    end

    function automatic logic [7:0] exp_rx(input logic full, input logic [7:0] held, input logic [7:0] fresh);
        return full ? held : fresh;
    endfunction : exp_rx

    task automatic stop_test;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] val, input logic [7:0] exp);
        check_count++;
        if (val !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask : chk

    task automatic put(input logic [7:0] b);
        @(posedge clk_sys);
        tx_data  <= b;
        tx_write <= 1'b1;
        @(posedge clk_sys);
        tx_write <= 1'b0;
        @(posedge clk_sys);
    endtask : put

    task automatic wait_for(input logic want_done);
        int n;
        n = 0;
        while ((want_done ? tx_done : tx_empty) !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 400) fails++;
        if (want_done) repeat (6) @(posedge clk_sys);
    endtask : wait_for

    task automatic clr;
        @(posedge clk_sys);
        rf_clr <= 1'b1;
        ov_clr <= 1'b1;
        @(posedge clk_sys);
        rf_clr <= 1'b0;
        ov_clr <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : clr

    // One duplex character with random data both ways
    task automatic xfer(input logic ext);
        logic [7:0] tb_byte, rb, held;
        logic       full;
        int         f0;
        tb_byte = 8'($random(seed));
        rb      = 8'($random(seed));
        full    = rx_full;
        held    = rx_hold;
        f0      = falls;
        @(posedge clk_sys);
        send_byte <= rb;
        arm       <= ~arm;
        put(tb_byte);
        if (ext) ext_go <= ~ext_go;
        wait_for(1'b1);
        chk(got, tb_byte);
        chk(8'(falls - f0), 8'h08);
        chk(rx_hold, exp_rx(full, held, rb));
        chk({rx_full, irq_rf}, 8'h03);
        chk({overrun, irq_re}, {6'h00, full, full});
        chk(tx_line, tb_byte[7]);
        chk({sck, irq_td}, 8'h03);
    endtask : xfer

    initial
    begin
        logic [7:0] b2;
        logic [10:0] fr;
        repeat (4) @(posedge clk_sys);
        chk({tx_line, sck, tx_empty, tx_done, rx_full, overrun, sck_oe}, 8'h78);
        rst   <= 1'b0;
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        ien   <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({irq_te, irq_td}, 8'h03);
        repeat (4) begin xfer(1'b0); clr(); end
        xfer(1'b0);
        xfer(1'b0);
        clr();
        b2 = 8'($random(seed));
        send_byte <= 8'h81;
        arm       <= ~arm;
        falls = 0;
        put(8'h5a);
        wait_for(1'b0);
        put(b2);
        wait_for(1'b1);
        chk(got, b2);
        chk(8'(falls), 8'h10);
        chk(rx_hold, 8'h81);
        chk({7'h00, overrun}, 8'h01);
        put(8'h3c);
        repeat (100) @(posedge clk_sys);
        chk({tx_empty, 7'(falls)}, 8'h10);
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({tx_empty, rx_full, overrun}, 8'h07);
        chk(rx_hold, 8'h81);
        clr();
        b2 = 8'($random(seed));
        send_byte <= b2;
        arm       <= ~arm;
        rx_en     <= 1'b1;
        falls      = 0;
        repeat (120) @(posedge clk_sys);
        chk(rx_hold, b2);
        chk({rx_full, 7'(falls)}, 8'h88);
        rx_en <= 1'b0;
        clr();
        tx_en  <= 1'b1;
        rx_en  <= 1'b1;
        sel_hi <= 1'b1;
        repeat (3) begin xfer(1'b1); clr(); end
        sel_hi    <= 1'b0;
        sync_mode <= 1'b0;
        mp        <= 1'b1;
        ext_err   <= 1'b1;
        mp_addr   <= 1'($random(seed));
        b2         = 8'($random(seed));
        put(b2);
        repeat (20) @(posedge clk_sys);
        chk({7'h00, tx_empty}, 8'h00);
        ext_err <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 11; i++)
        begin
            repeat ((i == 0) ? 4 : 8) @(posedge clk_sys);
            fr = {tx_line, fr[10:1]};
        end
        chk(fr[8:1], b2);
        chk({5'h00, fr[10:9], fr[0]}, {5'h00, 1'b1, mp_addr, 1'b0});
        wait_for(1'b1);
        chk({5'h00, tx_line, tx_done, irq_td}, 8'h07);
        stop_test();
    end
endmodule : sync_serial_and_multidrop_port_tb
`default_nettype wire
